// ==== core/pvic_pkg.sv ====
`default_nettype none
package pvic_pkg;

    // Source and vector counts.
    localparam int NSRC = 24;
    localparam int NVEC = 10;

    // Priority levels, larger value outranks smaller.
    localparam logic [1:0] LVL_LOW  = 2'h0;
    localparam logic [1:0] LVL_HIGH = 2'h1;
    localparam logic [1:0] LVL_TOP  = 2'h2;

    // Vector address of index i is VEC_FIRST + i * VEC_STEP.
    localparam logic [19:0] VEC_FIRST = 20'h00003;
    localparam logic [19:0] VEC_STEP  = 20'h00008;

    // Source bit positions in the request and flag vectors.
    localparam int SRC_EXT0   = 0;
    localparam int SRC_EXT1   = 1;
    localparam int SRC_EXT2   = 2;
    localparam int SRC_REMOTE = 5;
    localparam int SRC_PORT0  = 20;

    // Vector index of each source, four bits per source, source 0 lowest.
    localparam logic [95:0] SRC_VEC_MAP = 96'h9999_8887_7665_5433_3322_2210;

    // Sources able to end the full hold, extra ones for crystal hold, level-only pins.
    localparam logic [23:0] HOLD_WAKE_MASK  = 24'h100097;
    localparam logic [23:0] XHOLD_WAKE_MASK = 24'h000320;
    localparam logic [23:0] EXT01_MASK      = 24'h000003;

    // Register byte offsets.
    localparam logic [7:0] OFS_LVL_SEL   = 8'h00;
    localparam logic [7:0] OFS_SRC_EN    = 8'h04;
    localparam logic [7:0] OFS_SRC_FLAG  = 8'h08;
    localparam logic [7:0] OFS_CTRL      = 8'h0c;
    localparam logic [7:0] OFS_FLAG_LIST = 8'h10;
    localparam logic [7:0] OFS_STATUS    = 8'h14;

    // Control register fields.
    localparam int CTRL_GEN    = 0;
    localparam int CTRL_LVLDET = 1;
    localparam int CTRL_SB     = 4;

    // Status register fields.
    localparam int STAT_ISV = 0;
    localparam int STAT_IDX = 4;
    localparam int STAT_REQ = 8;
    localparam int STAT_LVL = 9;

    // Reset values.
    localparam logic [23:0] SRC_EN_RST  = 24'hffffff;
    localparam logic [9:0]  LVL_SEL_RST = 10'h000;

    // Standby states, Gray coded along run, halt, hold, crystal hold.
    typedef enum logic [1:0] {
        SB_RUN   = 2'b00,
        SB_HALT  = 2'b01,
        SB_HOLD  = 2'b11,
        SB_XHOLD = 2'b10
    } pvic_standby_t;

    // Arbitration result.
    typedef struct packed {
        logic       valid;
        logic [3:0] idx;
        logic [1:0] lvl;
    } pvic_grant_t;

    // Whole state of the controller.
    typedef struct packed {
        logic [23:0]   flag;
        logic [23:0]   en;
        logic [9:0]    lvl_sel;
        logic          gen;
        logic [1:0]    lvldet;
        logic [2:0]    isv;
        logic [23:0]   list;
        pvic_standby_t sb;
        logic          req;
        logic [3:0]    idx;
        logic [1:0]    lvl;
        logic [19:0]   vaddr;
        logic          pready;
        logic          pslverr;
        logic [31:0]   prdata;
    } pvic_state_t;

    // Vector index that a source is wired to.
    function automatic logic [3:0] vec_of(input int src);
        vec_of = SRC_VEC_MAP[4*src +: 4];
    endfunction : vec_of

    // Level of a vector: the first two choose top or low, the rest high or low.
    function automatic logic [1:0] vec_level(input logic sel, input int v);
        if (!sel) begin
            vec_level = LVL_LOW;
        end else if (v < 2) begin
            vec_level = LVL_TOP;
        end else begin
            vec_level = LVL_HIGH;
        end
    endfunction : vec_level

    // A level is admitted only if nothing at or above it is in service.
    function automatic logic lvl_allowed(input logic [1:0] lvl, input logic [2:0] isv);
        lvl_allowed = ((isv >> lvl) == 3'h0);
    endfunction : lvl_allowed

endpackage : pvic_pkg
`default_nettype wire

// ==== core/pvic_arbiter.sv ====
`timescale 1ns/1ps
`default_nettype none
module pvic_arbiter
    import pvic_pkg::*;
(
    input  wire logic [9:0] vec_pend,
    input  wire logic [9:0] lvl_sel,
    input  wire logic [2:0] isv,
    output pvic_grant_t     grant
);

    logic [1:0] l;

    // Ascending scan with a strict compare keeps the smallest index among equals.
    always_comb begin
        grant = '0;
        l     = LVL_LOW;
        for (int i = 0; i < NVEC; i++) begin
            l = vec_level(lvl_sel[i], i);
            if (vec_pend[i] && lvl_allowed(l, isv) && (!grant.valid || l > grant.lvl)) begin
                grant.valid = 1'b1;
                grant.idx   = 4'(i);
                grant.lvl   = l;
            end
        end
    end

endmodule : pvic_arbiter
`default_nettype wire

// ==== core/pvic_ctrl.sv ====
// Operation
// - Three levels low, high and top, top outranks high outranks low.
// - Requests at or below the level in service are not accepted.
// - Of simultaneous vectors, the highest level is granted first.
// - Among equal levels, the smallest vector address wins.
// - Twenty-four sources funnel onto ten vectors, seven of them shared.
// - Vectors 03h and 0Bh serve pins zero and one, top or low.
// - Vector 13h shares pins two, four, timer zero low, remote receiver; high or low.
// - Vector 1Bh shares pins three, five, base timers; 23h serves timer zero high.
// - 2Bh timer one halves; 33h serial zero or receive; 3Bh serial one or transmit.
// - 43h converter, timers six, seven; 4Bh port zero, timers four, five, PWM.
// - A readable list shows which sources caused the last branch.
// - Any acceptable interrupt ends the halt state.
// - Pins zero, one, two, four, five and port zero end the hold state.
// - Pins zero and one wake from hold only under level detection.
// - Crystal hold also wakes on base timer and remote receiver events.
`timescale 1ns/1ps
`default_nettype none
module pvic_ctrl
    import pvic_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic [23:0] src_evt,
    input  wire logic        irq_ack,
    input  wire logic        irq_ret,
    output logic             irq_req,
    output logic      [19:0] irq_vec_addr,
    output logic      [1:0]  irq_lvl,
    output logic      [1:0]  standby_mode
);

    pvic_state_t s_r;
    pvic_state_t s_nxt;
    logic [9:0]  vec_pend;
    pvic_grant_t grant;
    logic [23:0] act;
    logic [23:0] wake_src;
    logic        wr_en;
    logic        rd_setup;
    logic        mapped;

    // Enabled pending sources.
    assign act = s_r.flag & s_r.en;

    generate
        for (genvar v = 0; v < NVEC; v++) begin : g_vec
            logic [23:0] hit;
            for (genvar k = 0; k < NSRC; k++) begin : g_src
                assign hit[k] = act[k] && (vec_of(k) == 4'(v));
            end
            assign vec_pend[v] = |hit;
        end
    endgenerate

    pvic_arbiter u_arb (
        .vec_pend (vec_pend),
        .lvl_sel  (s_r.lvl_sel),
        .isv      (s_r.isv),
        .grant    (grant)
    );

    // Wake sources: pins zero and one count only with level detection chosen.
    // level-only pins.
    always_comb begin
        wake_src = HOLD_WAKE_MASK & ~EXT01_MASK;
        wake_src[SRC_EXT0] = s_r.lvldet[0];
        wake_src[SRC_EXT1] = s_r.lvldet[1];
        if (s_r.sb == SB_XHOLD) begin
            wake_src = wake_src | XHOLD_WAKE_MASK;
        end
    end

    // Bus decode; the slave answers in the first access cycle.
    assign wr_en    = psel && penable && s_r.pready && pwrite;
    assign rd_setup = psel && !penable;
    assign mapped   = (paddr <= OFS_STATUS) && (paddr[1:0] == 2'h0);

    // Next-state logic for the whole controller.
    always_comb begin
        s_nxt = s_r;
        // Bus answer is staged in the setup cycle so pready comes from a flop.
        s_nxt.pready  = rd_setup;
        s_nxt.pslverr = rd_setup && !mapped;
        s_nxt.prdata  = 32'h0;
        if (rd_setup && !pwrite) begin
            case (paddr)
                OFS_LVL_SEL:   s_nxt.prdata = {22'h0, s_r.lvl_sel};
                OFS_SRC_EN:    s_nxt.prdata = {8'h0, s_r.en};
                OFS_SRC_FLAG:  s_nxt.prdata = {8'h0, s_r.flag};
                OFS_CTRL:      s_nxt.prdata = {26'h0, s_r.sb, 1'b0, s_r.lvldet, s_r.gen};
                OFS_FLAG_LIST: s_nxt.prdata = {8'h0, s_r.list};
                OFS_STATUS:    s_nxt.prdata = {21'h0, s_r.lvl, s_r.req, s_r.idx, 1'b0, s_r.isv};
                default:       s_nxt.prdata = 32'h0;
            endcase
        end
        // Register writes; flags are write-one-to-clear.
        if (wr_en) begin
            case (paddr)
                OFS_LVL_SEL:  s_nxt.lvl_sel = pwdata[9:0];
                OFS_SRC_EN:   s_nxt.en = pwdata[23:0];
                OFS_SRC_FLAG: s_nxt.flag = s_r.flag & ~pwdata[23:0];
                OFS_CTRL: begin
                    s_nxt.gen    = pwdata[CTRL_GEN];
                    s_nxt.lvldet = pwdata[CTRL_LVLDET +: 2];
                    s_nxt.sb     = pvic_standby_t'(pwdata[CTRL_SB +: 2]);
                end
                default: ;
            endcase
        end
        // flags stay until cleared; a new event wins over a clear.
        s_nxt.flag = s_nxt.flag | src_evt;
        // Return from service drops the highest in-service level first.
        if (irq_ret) begin
            if (s_r.isv[2]) begin
                s_nxt.isv[2] = 1'b0;
            end else if (s_r.isv[1]) begin
                s_nxt.isv[1] = 1'b0;
            end else begin
                s_nxt.isv[0] = 1'b0;
            end
        end
        // the acknowledged level enters service and masks its peers.
        if (irq_ack && s_r.req) begin
            s_nxt.isv[s_r.lvl] = 1'b1;
            for (int k = 0; k < NSRC; k++) begin
                s_nxt.list[k] = act[k] && (vec_of(k) == s_r.idx);
            end
        end
        // request follows the arbiter.
        // A stale request is dropped in the ack cycle while service state settles.
        s_nxt.req = grant.valid && s_r.gen && !irq_ack && !irq_ret;
        if (grant.valid) begin
            s_nxt.idx   = grant.idx;
            s_nxt.lvl   = grant.lvl;
            s_nxt.vaddr = VEC_FIRST + 20'(grant.idx) * VEC_STEP;
        end
        // Standby release.
        case (s_r.sb)
            // halt ends on an admissible interrupt.
            SB_HALT: if (grant.valid && s_r.gen) begin
                s_nxt.sb = SB_RUN;
            end
            SB_HOLD, SB_XHOLD: if (|(act & wake_src)) begin
                s_nxt.sb = SB_RUN;
            end
            default: ;
        endcase
    end

    // Single state register.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_r         <= '0;
            s_r.en      <= SRC_EN_RST;
            s_r.lvl_sel <= LVL_SEL_RST;
            s_r.sb      <= SB_RUN;
        end else begin
            s_r <= s_nxt;
        end
    end

    // Outputs straight from the state register.
    assign prdata       = s_r.prdata;
    assign pready       = s_r.pready;
    assign pslverr      = s_r.pslverr;
    assign irq_req      = s_r.req;
    assign irq_vec_addr = s_r.vaddr;
    assign irq_lvl      = s_r.lvl;
    assign standby_mode = s_r.sb;

    // Checker helpers: is there a better candidate than the current grant.
    logic [9:0] better_lvl;
    logic [9:0] better_idx;
    generate
        for (genvar v = 0; v < NVEC; v++) begin : g_chk
            logic [1:0] lv;
            assign lv = vec_level(s_r.lvl_sel[v], v);
            assign better_lvl[v] = vec_pend[v] && lvl_allowed(lv, s_r.isv) && lv > grant.lvl;
            assign better_idx[v] = vec_pend[v] && lv == grant.lvl && 4'(v) < grant.idx;
        end
    endgenerate

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    property p_level_range;
        irq_req |-> irq_lvl != 2'h3 && (irq_vec_addr < 20'h00013 || irq_lvl != LVL_TOP);
    endproperty
    a_level_range: assert property (p_level_range) else $error("bad request level");

    property p_block;
        irq_req |-> lvl_allowed(irq_lvl, s_r.isv) || $past(irq_ret);
    endproperty
    a_block: assert property (p_block) else $error("request at or below service level");

    property p_high_first;
        grant.valid |-> better_lvl == 10'h0;
    endproperty
    a_high_first: assert property (p_high_first) else $error("higher level passed over");

    property p_small_first;
        grant.valid |-> better_idx == 10'h0;
    endproperty
    a_small_first: assert property (p_small_first) else $error("smaller vector passed over");

    property p_flag_set;
        src_evt[SRC_REMOTE] |=> s_r.flag[SRC_REMOTE];
    endproperty
    a_flag_set: assert property (p_flag_set) else $error("event flag lost");

    property p_vec_addr;
        irq_req |-> irq_vec_addr == VEC_FIRST + 20'(s_r.idx) * VEC_STEP;
    endproperty
    a_vec_addr: assert property (p_vec_addr) else $error("vector address mismatch");

    property p_list;
        irq_ack && irq_req |=> s_r.list == ($past(act) & s_r.list) && s_r.list != 24'h0;
    endproperty
    a_list: assert property (p_list) else $error("source list not captured");

    property p_halt_wake;
        standby_mode == SB_HALT && grant.valid && s_r.gen |=> standby_mode == SB_RUN;
    endproperty
    a_halt_wake: assert property (p_halt_wake) else $error("halt not released");

    property p_hold_wake;
        standby_mode == SB_HOLD && act[SRC_PORT0] && !wr_en |=> standby_mode == SB_RUN;
    endproperty
    a_hold_wake: assert property (p_hold_wake) else $error("hold not released");

    property p_edge_pin;
        standby_mode == SB_HOLD && !s_r.lvldet[0] && act == 24'h000001 && !wr_en && src_evt == 24'h0
            |=> standby_mode == SB_HOLD;
    endproperty
    a_edge_pin: assert property (p_edge_pin) else $error("edge pin released hold");

    property p_xhold_wake;
        standby_mode == SB_XHOLD && act[SRC_REMOTE] && !wr_en |=> standby_mode == SB_RUN;
    endproperty
    a_xhold_wake: assert property (p_xhold_wake) else $error("crystal hold not released");

    property p_pending;
        (s_r.flag[SRC_EXT2] && !(wr_en && paddr == OFS_SRC_FLAG)) [*2] |=> s_r.flag[SRC_EXT2];
    endproperty
    a_pending: assert property (p_pending) else $error("blocked request dropped");

    property p_pin_vec;
        act[SRC_EXT0] |-> vec_pend[0];
    endproperty
    a_pin_vec: assert property (p_pin_vec) else $error("pin zero off its vector");

    property p_shared_vec;
        act[SRC_EXT2] || act[SRC_REMOTE] |-> vec_pend[2];
    endproperty
    a_shared_vec: assert property (p_shared_vec) else $error("shared vector two not raised");

    property p_port_vec;
        act[SRC_PORT0] |-> vec_pend[NVEC-1];
    endproperty
    a_port_vec: assert property (p_port_vec) else $error("port source off the last vector");

    property p_ack_drop;
        irq_ack && irq_req |=> !irq_req && s_r.isv != 3'h0;
    endproperty
    a_ack_drop: assert property (p_ack_drop) else $error("acknowledge did not enter service");

    property p_halt_stay;
        standby_mode == SB_HALT && !grant.valid && !wr_en |=> standby_mode == SB_HALT;
    endproperty
    a_halt_stay: assert property (p_halt_stay) else $error("halt left without interrupt");

    property p_xhold_extra;
        standby_mode == SB_XHOLD && (act & XHOLD_WAKE_MASK) != 24'h0 && !wr_en |=> standby_mode == SB_RUN;
    endproperty
    a_xhold_extra: assert property (p_xhold_extra) else $error("crystal hold ignored timer wake");

    property p_hold_extra;
        standby_mode == SB_HOLD && (act & ~XHOLD_WAKE_MASK) == 24'h0 && !wr_en |=> standby_mode == SB_HOLD;
    endproperty
    a_hold_extra: assert property (p_hold_extra) else $error("full hold left on crystal source");

endmodule : pvic_ctrl
`default_nettype wire

// ==== dv/pvic_core_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module pvic_core_model (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        ack_en,
    input  wire logic [1:0]  ack_delay,
    input  wire logic        irq_req,
    input  wire logic [19:0] irq_vec_addr,
    input  wire logic [1:0]  irq_lvl,
    output logic             irq_ack,
    output logic      [19:0] taken_vec,
    output logic      [1:0]  taken_lvl,
    output logic      [7:0]  take_cnt
);
    logic [1:0] wait_r;

    // Core takes a vector after a chosen delay, so both prompt and slow fetches occur.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_ack   <= 1'b0;
            wait_r    <= 2'h0;
            taken_vec <= 20'h00000;
            taken_lvl <= 2'h0;
            take_cnt  <= 8'h00;
        end else if (irq_ack) begin
            irq_ack   <= 1'b0; // The vector is recorded as the acknowledge drops, one edge after it rose.
            taken_vec <= irq_vec_addr;
            taken_lvl <= irq_lvl;
            take_cnt  <= take_cnt + 8'h01;
        end else if (ack_en && irq_req) begin
            if (wait_r == ack_delay) begin
                irq_ack <= 1'b1;
                wait_r  <= 2'h0;
            end else begin
                wait_r <= wait_r + 2'h1;
            end
        end
    end
endmodule : pvic_core_model
`default_nettype wire

// ==== dv/tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb_top
    import pvic_pkg::*;
;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, rdat;
    logic        pready, pslverr, rerr;
    logic [23:0] src_evt = 24'h0;
    logic        irq_ack, irq_ret = 1'b0, irq_req, ack_en = 1'b0;
    logic [19:0] irq_vec_addr, taken_vec;
    logic [1:0]  irq_lvl, standby_mode, taken_lvl, dly = 2'h0;
    logic [7:0]  take_cnt;
    logic [16:0] sb_tab [14] = '{17'h1110a, 17'h0310a, 17'h13102, 17'h13114, 17'h03100, 17'h13300,
        17'h03108, 17'h12108, 17'h12105, 17'h03105, 17'h13501, 17'h02101, 17'h13107, 17'h13104};
    int          vt [24] = '{0, 1, 2, 2, 2, 2, 3, 3, 3, 3, 4, 5, 5, 6, 6, 7, 7, 8, 8, 8, 9, 9, 9, 9};
    int          err_count = 0;
    int          checked = 0;
    int          cyc = 0;

    // Free-running clock; a cycle ceiling cuts a hang short.
    always #25 clk = ~clk;
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_count++;
            end_of_test();
        end
    end

    pvic_ctrl i_dut (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .src_evt(src_evt), .irq_ack(irq_ack), .irq_ret(irq_ret), .irq_req(irq_req),
        .irq_vec_addr(irq_vec_addr), .irq_lvl(irq_lvl), .standby_mode(standby_mode));
    pvic_core_model i_core (.clk(clk), .rst_n(rst_n), .ack_en(ack_en), .ack_delay(dly),
        .irq_req(irq_req), .irq_vec_addr(irq_vec_addr), .irq_lvl(irq_lvl), .irq_ack(irq_ack),
        .taken_vec(taken_vec), .taken_lvl(taken_lvl), .take_cnt(take_cnt));

    task automatic end_of_test();
        if (err_count == 0 && checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : end_of_test

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            err_count++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    // One APB transfer; the request holds until pready is seen at an edge.
    // Only the bench's cycle ceiling ends a wait that never sees pready.
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rdat    = prdata;
        rerr    = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask : apb

    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp, input logic e);
        apb(1'b0, a, 32'h0);
        chk("prdata", rdat, exp);
        chk("pslverr", {31'h0, rerr}, {31'h0, e});
    endtask : rdchk

    task automatic pulse(input logic [23:0] m);
        src_evt <= m;
        @(posedge clk);
        src_evt <= 24'h0;
        @(posedge clk);
    endtask : pulse

    task automatic ret();
        irq_ret <= 1'b1;
        @(posedge clk);
        irq_ret <= 1'b0;
        repeat (3) @(posedge clk);
    endtask : ret

    // Let the core model take one vector, waiting a bounded time.
    task automatic take();
        logic [7:0] c;
        int         n = 0;
        c = take_cnt;
        ack_en <= 1'b1;
        while (take_cnt === c && n < 20) begin
            @(posedge clk);
            n++;
        end
        ack_en <= 1'b0;
        chk("ack_taken", {31'h0, n < 20}, 32'h1);
    endtask : take

    task automatic do_reset();
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
    endtask : do_reset

    // Reset values, an unmapped address and a read-only list.
    task automatic t_regs();
        rdchk(OFS_SRC_EN, 32'h00ffffff, 1'b0);
        rdchk(OFS_LVL_SEL, 32'h0, 1'b0);
        rdchk(OFS_CTRL, 32'h0, 1'b0);
        rdchk(8'h18, 32'h0, 1'b1);
        apb(1'b1, OFS_FLAG_LIST, 32'hffffffff);
        rdchk(OFS_FLAG_LIST, 32'h0, 1'b0);
        chk("standby", {30'h0, standby_mode}, 32'h0);
    endtask : t_regs

    // Every source reaches its vector and shows in the list.
    task automatic t_map();
        do_reset();
        dly <= 2'h2;
        apb(1'b1, OFS_CTRL, 32'h1);
        for (int s = 0; s < 24; s++) begin
            pulse(24'h1 << s);
            take();
            chk("vector", {12'h0, taken_vec}, 32'(VEC_FIRST + VEC_STEP * vt[s]));
            chk("level", {30'h0, taken_lvl}, {30'h0, LVL_LOW});
            rdchk(OFS_FLAG_LIST, 32'h1 << s, 1'b0);
            apb(1'b1, OFS_SRC_FLAG, 32'h1 << s);
            ret();
            chk("req_clear", {31'h0, irq_req}, 32'h0);
        end
        dly <= 2'h0;
    endtask : t_map

    // Level order, blocking, nesting and the smallest vector among equals.
    task automatic t_prio();
        do_reset();
        apb(1'b1, OFS_CTRL, 32'h1);
        apb(1'b1, OFS_LVL_SEL, 32'h201);
        pulse(24'h100040);
        take();
        chk("vector", {12'h0, taken_vec}, 32'h4b);
        chk("level", {30'h0, taken_lvl}, {30'h0, LVL_HIGH});
        pulse(24'h000800);
        repeat (3) @(posedge clk);
        chk("blocked", {31'h0, irq_req}, 32'h0);
        pulse(24'h000001);
        take();
        chk("vector", {12'h0, taken_vec}, 32'h03);
        chk("level", {30'h0, taken_lvl}, {30'h0, LVL_TOP});
        apb(1'b1, OFS_SRC_FLAG, 32'h100001);
        ret();
        chk("blocked", {31'h0, irq_req}, 32'h0);
        ret();
        take();
        chk("vector", {12'h0, taken_vec}, 32'h1b);
        chk("level", {30'h0, taken_lvl}, {30'h0, LVL_LOW});
    endtask : t_prio

    // Global and per-source enables hold a flagged request back.
    task automatic t_enable();
        do_reset();
        pulse(24'h000400);
        repeat (3) @(posedge clk);
        chk("gen_off", {31'h0, irq_req}, 32'h0);
        rdchk(OFS_SRC_FLAG, 32'h400, 1'b0);
        apb(1'b1, OFS_SRC_EN, 32'h00fffbff);
        apb(1'b1, OFS_CTRL, 32'h1);
        // Give the new global enable time to reach the request flop first.
        repeat (2) @(posedge clk);
        chk("src_off", {31'h0, irq_req}, 32'h0);
        apb(1'b1, OFS_SRC_EN, 32'h00ffffff);
        repeat (2) @(posedge clk);
        chk("vector", {12'h0, irq_vec_addr}, 32'h23);
        rdchk(OFS_STATUS, 32'h140, 1'b0);
    endtask : t_enable

    // Each standby state against sources that must or must not end it.
    task automatic t_standby();
        logic [31:0] exp_sb;
        for (int i = 0; i < 14; i++) begin
            do_reset();
            apb(1'b1, OFS_CTRL, {24'h0, sb_tab[i][15:8]});
            chk("sb_enter", {30'h0, standby_mode}, {30'h0, sb_tab[i][13:12]});
            pulse(24'h1 << sb_tab[i][4:0]);
            repeat (4) @(posedge clk);
            // A woken block reads run, a sleeping one still shows the mode written.
            exp_sb = sb_tab[i][16] ? 32'h0 : {30'h0, sb_tab[i][13:12]};
            chk("sb_exit", {30'h0, standby_mode}, exp_sb);
        end
    endtask : t_standby

    initial begin
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        t_regs();
        t_map();
        t_prio();
        t_enable();
        t_standby();
        end_of_test();
    end
endmodule : tb_top
`default_nettype wire
